// ### verilog/scc_uart.sv
`timescale 1ns/1ps
`include "scc_map.svh"
module scc_uart (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic port_clk_on,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_in,
  output logic rx_oe_n,
  output logic tx_out,
  output logic tx_oe_n,
  output logic irq,
  output logic wake_req
);
  logic [7:0] ctrl1;
  logic [7:0] serial_control_two;
  logic [7:0] baud_divisor_reg;
  logic tx_ninth_bit;
  logic rx_ninth_bit;
  logic [7:0] tx_hold;
  logic tx_full;
  logic [7:0] rx_data;
  logic rx_data_avail_flag, overrun_flag, tx_idle_flag, tx_empty_flag, irq_flag;
  logic rx_s, rx_d;
  logic tx_run, rx_run, port_on;
  logic wr, rd, data_wr, data_rd;
  scc_pkg::scc_tx_state_t tx_st;
  scc_pkg::scc_rx_state_t rx_st;
  logic [9:0] tx_sh;
  logic [3:0] tx_cnt;
  logic [3:0] rx_os;
  logic [3:0] rx_cnt;
  logic [8:0] rx_sh;
  logic rx_idle;
  logic rx_done;
  logic [8:0] rx_word;
  scc_tick_if tk ();

  assign port_on = ctrl1[`SCC_C1_ON];
  assign tx_run = port_on && serial_control_two[`SCC_C2_TX_ENABLE_BIT];
  assign rx_run = port_on && serial_control_two[`SCC_C2_RX_ENABLE_BIT];
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign data_wr = wr && paddr == `SCC_DATA_OFS;
  assign data_rd = rd && paddr == `SCC_DATA_OFS;

  assign tk.run = port_on;
  assign tk.high_speed = serial_control_two[`SCC_C2_BAUD_HIGH_SPEED_SEL];
  assign tk.divisor = baud_divisor_reg;
  scc_baud u_baud (.core_clk(core_clk), .rst_n(rst_n), .tk(tk));
  scc_sync u_rx_sync (.core_clk(core_clk), .rst_n(rst_n), .din(rx_in), .dout(rx_s));

  function automatic logic [7:0] fit8(input logic [31:0] v);
    fit8 = v[7:0];
  endfunction

  // apb: zero wait states, unmapped reads zero and flag an error
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `SCC_CTRL1_OFS: prdata <= {24'h000000, ctrl1[7:2], rx_ninth_bit, 1'b0};
          `SCC_CTRL2_OFS: prdata <= {24'h000000, serial_control_two};
          `SCC_STAT_OFS: prdata <= {24'h000000, irq_flag, wake_req, 1'b0, overrun_flag, rx_idle,
                                    rx_data_avail_flag, tx_idle_flag, tx_empty_flag};
          `SCC_DATA_OFS: prdata <= {24'h000000, rx_data};
          `SCC_DIV_OFS: prdata <= {24'h000000, baud_divisor_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  // pready pulses in the access cycle; registers below take writes on that edge

  // control registers; port off clears enables and break but keeps config
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl1 <= `SCC_CTRL_RST;
      serial_control_two <= `SCC_CTRL_RST;
      baud_divisor_reg <= `SCC_DIV_RST;
      tx_ninth_bit <= 1'b0;
    end else begin
      if (wr && pready && paddr == `SCC_CTRL1_OFS) begin
        ctrl1 <= {pwdata[7:2], 2'b00};
        tx_ninth_bit <= pwdata[`SCC_C1_TX8];
      end
      if (wr && pready && paddr == `SCC_CTRL2_OFS) serial_control_two <= fit8(pwdata);
      if (wr && pready && paddr == `SCC_DIV_OFS) baud_divisor_reg <= fit8(pwdata);
      if (!port_on) begin
        serial_control_two[`SCC_C2_TX_ENABLE_BIT] <= 1'b0;
        serial_control_two[`SCC_C2_RX_ENABLE_BIT] <= 1'b0;
        ctrl1[`SCC_C1_BRK] <= 1'b0;
      end
    end
  end

  // transmitter
  always_ff @(posedge core_clk) begin
    if (!rst_n || !tx_run) begin
      tx_st <= scc_pkg::scc_tx_idle;
      tx_full <= 1'b0;
      tx_hold <= 8'h00;
      tx_sh <= 10'h3ff;
      tx_cnt <= 4'h0;
      tx_out <= 1'b1;
      tx_oe_n <= 1'b1;
    end else begin
      tx_oe_n <= 1'b0;
      if (data_wr && pready) begin
        tx_hold <= fit8(pwdata);
        tx_full <= 1'b1;
      end
      case (tx_st)
        scc_pkg::scc_tx_idle: begin
          tx_out <= 1'b1;
          if (tk.bit_tick && tx_full) begin
            // frame after start: data, optional ninth, then stop_count_sel
            tx_sh <= {1'b1, tx_ninth_bit, tx_hold};
            tx_out <= 1'b0;
            // bits = 8 or 9 data plus 1 or 2 stop_count_sel
            // count runs out on the last stop, so no spare idle bit sits between frames
            tx_cnt <= 4'h8 + {3'h0, ctrl1[`SCC_C1_NINE]} + {3'h0, ctrl1[`SCC_C1_STOP]};
            if (!ctrl1[`SCC_C1_NINE]) tx_sh[8] <= 1'b1;
            tx_full <= data_wr && pready;
            tx_st <= scc_pkg::scc_tx_shift;
          end else if (tk.bit_tick && ctrl1[`SCC_C1_BRK]) begin
            tx_out <= 1'b0;
            tx_cnt <= `SCC_BREAK_BITS;
            tx_st <= scc_pkg::scc_tx_break;
          end
        end
        scc_pkg::scc_tx_shift: begin
          if (tk.bit_tick) begin
            tx_out <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_cnt <= tx_cnt - 4'h1;
            if (tx_cnt == 4'h0) begin
              tx_out <= 1'b1;
              tx_st <= scc_pkg::scc_tx_idle;
            end
          end
        end
        scc_pkg::scc_tx_break: begin
          // held low for at least 14 bit times and until the request is withdrawn
          if (tk.bit_tick && tx_cnt != 4'h0) tx_cnt <= tx_cnt - 4'h1;
          if (tk.bit_tick && tx_cnt == 4'h0 && !ctrl1[`SCC_C1_BRK]) begin
            tx_out <= 1'b1;
            tx_st <= scc_pkg::scc_tx_idle;
          end
        end
        default: tx_st <= scc_pkg::scc_tx_idle;
      endcase
    end
  end

  // empty and idle flags; a disabled transmitter reports both set
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_empty_flag <= 1'b1;
      tx_idle_flag <= 1'b1;
    end else begin
      tx_empty_flag <= !tx_full || !tx_run;
      tx_idle_flag <= !tx_run || (!tx_full && tx_st == scc_pkg::scc_tx_idle && !ctrl1[`SCC_C1_BRK]);
    end
  end

  // receiver, 16x oversampled, single stop bit
  assign rx_word = ctrl1[`SCC_C1_NINE] ? rx_sh : {1'b0, rx_sh[8:1]};
  always_ff @(posedge core_clk) begin
    if (!rst_n || !rx_run) begin
      rx_st <= scc_pkg::scc_rx_idle;
      rx_os <= 4'h0;
      rx_cnt <= 4'h0;
      rx_sh <= 9'h000;
      rx_d <= 1'b1;
      rx_done <= 1'b0;
      rx_oe_n <= 1'b1;
    end else begin
      rx_oe_n <= 1'b0;
      rx_done <= 1'b0;
      if (tk.os_tick) begin
        rx_d <= rx_s;
        rx_os <= rx_os + 4'h1;
        case (rx_st)
          scc_pkg::scc_rx_idle: if (rx_d && !rx_s) begin
            rx_os <= 4'h0;
            rx_st <= scc_pkg::scc_rx_start;
          end
          scc_pkg::scc_rx_start: if (rx_os == 4'h7) begin
            rx_os <= 4'h0;
            rx_cnt <= ctrl1[`SCC_C1_NINE] ? 4'h9 : 4'h8;
            rx_st <= rx_s ? scc_pkg::scc_rx_idle : scc_pkg::scc_rx_data;
          end
          scc_pkg::scc_rx_data: if (rx_os == 4'hf) begin
            rx_sh <= {rx_s, rx_sh[8:1]};
            rx_cnt <= rx_cnt - 4'h1;
            if (rx_cnt == 4'h1) rx_st <= scc_pkg::scc_rx_stop;
          end
          scc_pkg::scc_rx_stop: if (rx_os == 4'hf) begin
            rx_done <= 1'b1;
            rx_st <= scc_pkg::scc_rx_idle;
          end
          default: rx_st <= scc_pkg::scc_rx_idle;
        endcase
      end
    end
  end
  assign rx_idle = (rx_st == scc_pkg::scc_rx_idle);

  // receive buffer, flags; hardware set wins over the clearing read
  always_ff @(posedge core_clk) begin
    if (!rst_n || !rx_run) begin
      rx_data <= 8'h00;
      rx_ninth_bit <= 1'b0;
      rx_data_avail_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      if (data_rd && pready) begin
        rx_data_avail_flag <= 1'b0;
        overrun_flag <= 1'b0;
      end
      // address bit is the top data bit of the frame
      if (rx_done && (!serial_control_two[`SCC_C2_ADDRESS_DETECT_EN] || (ctrl1[`SCC_C1_NINE] ? rx_word[8] : rx_word[7]))) begin
        if (rx_data_avail_flag && !(data_rd && pready)) begin
          overrun_flag <= 1'b1;
        end else begin
          rx_data <= rx_word[7:0];
          rx_ninth_bit <= rx_word[8];
          rx_data_avail_flag <= 1'b1;
        end
      end
    end
  end

  // port interrupt request: rises when an enabled flag sets or on wake_req; the flag part is cleared by status read
  logic tx_idle_q, tx_empty_q, rxf_q, ovr_q, irq_set;
  assign irq_set = (serial_control_two[`SCC_C2_RIE] && ((rx_data_avail_flag && !rxf_q)
                    || (overrun_flag && !ovr_q)))
                || (serial_control_two[`SCC_C2_TX_IDLE_IRQ_EN] && tx_idle_flag && !tx_idle_q)
                || (serial_control_two[`SCC_C2_TX_EMPTY_IRQ_EN] && tx_empty_flag && !tx_empty_q);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_idle_q <= 1'b1;
      tx_empty_q <= 1'b1;
      rxf_q <= 1'b0;
      ovr_q <= 1'b0;
      irq_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      tx_idle_q <= tx_idle_flag;
      tx_empty_q <= tx_empty_flag;
      rxf_q <= rx_data_avail_flag;
      ovr_q <= overrun_flag;
      if (irq_set) irq_flag <= 1'b1;
      else if (rd && pready && paddr == `SCC_STAT_OFS) irq_flag <= 1'b0;
      irq <= irq_flag || wake_req;
    end
  end

  // own edge detector: rx_d only moves while the receiver runs, which would make wake level-sensitive
  logic rx_prev;
  always_ff @(posedge core_clk) begin
    if (!rst_n) rx_prev <= 1'b1;
    else rx_prev <= rx_s;
  end

  // wake request only while the port clock is stopped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else if (!port_clk_on && serial_control_two[`SCC_C2_WAKE] && rx_prev && !rx_s) begin
      wake_req <= 1'b1;
    end else if (port_clk_on) begin
      wake_req <= 1'b0;
    end
  end
endmodule

// ### verilog/scc_map.svh
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// register byte offsets
`define SCC_CTRL1_OFS 12'h000
`define SCC_CTRL2_OFS 12'h004
`define SCC_STAT_OFS 12'h008
`define SCC_DATA_OFS 12'h00c
`define SCC_DIV_OFS 12'h010
// control one field positions
`define SCC_C1_ON 7
`define SCC_C1_NINE 6
`define SCC_C1_STOP 3
`define SCC_C1_BRK 2
`define SCC_C1_RX8 1
`define SCC_C1_TX8 0
// control two field positions
`define SCC_C2_TX_ENABLE_BIT 7
`define SCC_C2_RX_ENABLE_BIT 6
`define SCC_C2_BAUD_HIGH_SPEED_SEL 5
`define SCC_C2_ADDRESS_DETECT_EN 4
`define SCC_C2_WAKE 3
`define SCC_C2_RIE 2
`define SCC_C2_TX_IDLE_IRQ_EN 1
`define SCC_C2_TX_EMPTY_IRQ_EN 0
// status field positions
`define SCC_ST_OVERRUN_FLAG 4
`define SCC_ST_RIDLE 3
`define SCC_ST_RX_DATA_AVAIL_FLAG 2
`define SCC_ST_TX_IDLE_FLAG 1
`define SCC_ST_TX_EMPTY_FLAG 0
`define SCC_ST_IRQ 7
`define SCC_ST_WAKE 6
// reset values
`define SCC_CTRL_RST 8'h00
`define SCC_DIV_RST 8'h00
// timing counts
`define SCC_LOW_OVS 7'h40
`define SCC_HIGH_OVS 7'h10
`define SCC_BREAK_BITS 4'hd
`endif

// ### verilog/scc_pkg.sv
package scc_pkg;
  typedef enum logic [1:0] {scc_tx_idle, scc_tx_shift, scc_tx_break} scc_tx_state_t;
  typedef enum logic [1:0] {scc_rx_idle, scc_rx_start, scc_rx_data, scc_rx_stop} scc_rx_state_t;
endpackage

// ### verilog/scc_tick_if.sv
`timescale 1ns/1ps
interface scc_tick_if;
  logic run;
  logic high_speed;
  logic [7:0] divisor;
  logic os_tick;
  logic bit_tick;
  modport gen (input run, input high_speed, input divisor, output os_tick, output bit_tick);
  modport use_side (output run, output high_speed, output divisor, input os_tick, input bit_tick);
endinterface

// ### verilog/scc_baud.sv
`timescale 1ns/1ps
// os_tick: 16 per bit period; bit_tick: once per bit period
module scc_baud (
  input wire logic core_clk,
  input wire logic rst_n,
  scc_tick_if.gen tk
);
  logic [7:0] pre;
  logic [1:0] slow;
  logic [3:0] ovs;
  logic pre_end;
  assign pre_end = (pre == tk.divisor);
  always_ff @(posedge core_clk) begin
    if (!rst_n || !tk.run) begin
      pre <= 8'h00;
      slow <= 2'h0;
      ovs <= 4'h0;
      tk.os_tick <= 1'b0;
      tk.bit_tick <= 1'b0;
    end else begin
      tk.os_tick <= 1'b0;
      tk.bit_tick <= 1'b0;
      if (pre_end) begin
        pre <= 8'h00;
        slow <= slow + 2'h1;
        // low speed divides a further four: 64 vs 16 clocks per unit
        if (tk.high_speed || slow == 2'h3) begin
          tk.os_tick <= 1'b1;
          ovs <= ovs + 4'h1;
          tk.bit_tick <= (ovs == 4'hf);
        end
      end else begin
        pre <= pre + 8'h01;
      end
    end
  end
endmodule

// ### verilog/scc_sync.sv
`timescale 1ns/1ps
module scc_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ### bench/scc_uart_checker.sv
`timescale 1ns/1ps
module scc_uart_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic port_clk_on,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_in,
  input wire logic rx_oe_n,
  input wire logic tx_out,
  input wire logic tx_oe_n,
  input wire logic irq,
  input wire logic wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] c1;
  logic [7:0] c2;
  logic [7:0] dv;
  logic [17:0] lows;
  logic [17:0] bp;
  logic ten;
  logic ren;
  assign bp = (c2[5] ? 18'h10 : 18'h40) * (18'(dv) + 18'h1);
  assign ten = c1[7] && c2[7];
  assign ren = c1[7] && c2[6];
  // shadows of software writes, so the pin gating can be judged from outside
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      c1 <= 8'h00;
      c2 <= 8'h00;
      dv <= 8'h00;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 12'h000) c1 <= pwdata[7:0];
      if (paddr == 12'h004) c2 <= pwdata[7:0];
      if (paddr == 12'h010) dv <= pwdata[7:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n || tx_out || tx_oe_n) lows <= 18'h0;
    else lows <= lows + 18'h1;
  end
  property p_bus;
    psel && penable |-> pready && (pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}));
  endproperty
  a_bus: assert property (p_bus) else $error("apb answer wrong");
  property p_txoff;
    $fell(ten) |-> ##[1:2] tx_oe_n;
  endproperty
  a_txoff: assert property (p_txoff) else $error("tx not released");
  property p_txgate;
    !tx_oe_n |-> ten || $past(ten);
  endproperty
  a_txgate: assert property (p_txgate) else $error("tx driven while off");
  property p_rxoff;
    $fell(ren) |-> ##[1:2] rx_oe_n;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("rx not released");
  property p_rxgate;
    !rx_oe_n |-> ren || $past(ren);
  endproperty
  a_rxgate: assert property (p_rxgate) else $error("rx owned while off");
  property p_wake;
    !port_clk_on && c2[3] && $fell(rx_in) |-> ##[1:6] (wake_req || port_clk_on);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request");
  property p_nowake;
    $rose(wake_req) |-> !$past(port_clk_on);
  endproperty
  a_nowake: assert property (p_nowake) else $error("wake with clock on");
  property p_brk;
    $rose(tx_out) && !tx_oe_n |-> lows <= 10 * bp + 2 || lows >= 13 * bp;
  endproperty
  a_brk: assert property (p_brk) else $error("low run too short for break");
  property p_irq;
    $rose(irq) |-> c2[2:0] != 3'h0 || $past(c2[2:0]) != 3'h0 || wake_req;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
endmodule

bind scc_uart scc_uart_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .port_clk_on(port_clk_on),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .rx_oe_n(rx_oe_n), .tx_out(tx_out),
  .tx_oe_n(tx_oe_n), .irq(irq), .wake_req(wake_req));

// ### bench/scc_remote.sv
`timescale 1ns/1ps
module scc_remote (
  input wire logic core_clk,
  input wire logic tx_out,
  input wire logic tx_oe_n,
  output logic rx_line
);
  // an async line idles high between frames
  initial rx_line = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input int bp);
    rx_line <= 1'b0;
    repeat (bp) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (bp) @(posedge core_clk);
    end
    rx_line <= 1'b1;
    repeat (bp) @(posedge core_clk);
  endtask
  // span runs from this start edge to the next one, so it shows the stop count
  task automatic get(input int nb, input int bp, output logic [8:0] d, output int span);
    d = 9'h000;
    while (tx_out !== 1'b0 || tx_oe_n !== 1'b0) @(posedge core_clk);
    repeat (bp / 2) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bp) @(posedge core_clk);
      d[i] = tx_out;
    end
    span = bp / 2 + nb * bp;
    while (tx_out !== 1'b0 && span < 20 * bp) begin
      @(posedge core_clk);
      span++;
    end
  endtask
endmodule

// ### bench/scc_uart_bench.sv
`timescale 1ns/1ps
module scc_uart_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic port_clk_on = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_oe_n, tx_out, tx_oe_n, irq, wake_req, rx_line, err;
  logic [31:0] r;
  logic [8:0] d;
  int span;
  int bad_count = 0;
  int checked = 0;
  always #2.5 core_clk = ~core_clk;
  scc_uart dut (.core_clk(core_clk), .rst_n(rst_n), .port_clk_on(port_clk_on), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in(rx_line), .rx_oe_n(rx_oe_n), .tx_out(tx_out), .tx_oe_n(tx_oe_n), .irq(irq), .wake_req(wake_req));
  scc_remote remote (.core_clk(core_clk), .tx_out(tx_out), .tx_oe_n(tx_oe_n), .rx_line(rx_line));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // trailing idle edges let register effects reach the pins before they are judged
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_regs();
    chk("tx_oe_n", 1, tx_oe_n);
    apb(0, 12'h004, 0);
    chk("ctrl2", 0, r);
    apb(1, 12'h004, 32'h30);
    apb(0, 12'h004, 0);
    chk("ctrl2 rw", 32'h30, r);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, err);
    $display("t_regs done");
  endtask
  task automatic t_tx(input logic [7:0] c1v, input logic [7:0] c2v, input int nb, input int bp, input int es,
    input logic [8:0] ed, input logic ei);
    apb(1, 12'h010, 0);
    apb(1, 12'h000, c1v);
    apb(1, 12'h004, c2v);
    fork
      remote.get(nb, bp, d, span);
      begin
        apb(1, 12'h00c, 32'ha5);
        repeat (3 * bp) @(posedge core_clk);
        apb(1, 12'h00c, 32'ha5);
      end
    join
    chk("tx data", ed, d);
    chk("frame span", 1, span >= es - 2 && span <= es + 2);
    repeat (14 * bp) @(posedge core_clk);
    chk("idle irq", ei, irq);
    apb(0, 12'h008, 0);
    chk("tx idle", 32'h3, r & 32'h3);
    $display("t_tx done");
  endtask
  task automatic t_rx();
    apb(1, 12'h000, 32'hc0);
    apb(1, 12'h004, 32'h74);
    chk("rx owned", 0, rx_oe_n);
    remote.send(9'h155, 9, 16);
    repeat (16) @(posedge core_clk);
    chk("addr irq", 1, irq);
    apb(0, 12'h000, 0);
    chk("ninth", 1, r[1]);
    apb(0, 12'h00c, 0);
    chk("rx data", 32'h55, r);
    apb(0, 12'h008, 0);
    remote.send(9'h0aa, 9, 16);
    repeat (16) @(posedge core_clk);
    chk("data irq", 0, irq);
    remote.send(9'h1f0, 9, 16);
    remote.send(9'h10f, 9, 16);
    apb(0, 12'h008, 0);
    chk("overrun", 32'h94, r & 32'h94);
    apb(0, 12'h00c, 0);
    chk("overrun keeps", 32'hf0, r);
    apb(1, 12'h004, 0);
    chk("rx float", 1, rx_oe_n);
    $display("t_rx done");
  endtask
  task automatic t_brk();
    apb(1, 12'h000, 32'h84);
    apb(1, 12'h004, 32'ha0);
    while (tx_out !== 1'b0) @(posedge core_clk);
    repeat (13 * 16) @(posedge core_clk);
    chk("break low", 0, tx_out);
    apb(1, 12'h000, 32'h80);
    repeat (40) @(posedge core_clk);
    chk("break end", 1, tx_out);
    apb(1, 12'h004, 0);
    apb(0, 12'h008, 0);
    apb(1, 12'h004, 32'ha1);
    apb(1, 12'h00c, 0);
    repeat (80) @(posedge core_clk);
    chk("tx driven", 0, tx_oe_n);
    chk("empty irq", 1, irq);
    apb(1, 12'h004, 0);
    chk("tx float", 1, tx_oe_n);
    $display("t_brk done");
  endtask
  task automatic t_wake();
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'h08);
    apb(0, 12'h008, 0);
    remote.send(9'h000, 8, 16);
    chk("wake clk on", 0, wake_req);
    chk("irq quiet", 0, irq);
    port_clk_on <= 1'b0;
    remote.send(9'h000, 8, 16);
    chk("wake", 1, wake_req);
    chk("wake irq", 1, irq);
    port_clk_on <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("wake clr", 0, wake_req);
    chk("wake irq clr", 0, irq);
    $display("t_wake done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_tx(8'hc9, 8'ha2, 9, 16, 192, 9'h1a5, 1'b1);
    t_tx(8'h80, 8'h80, 8, 64, 640, 9'h0a5, 1'b0);
    t_rx();
    t_brk();
    t_wake();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    $display("watchdog expired");
    bad_count++;
    finish_test();
  end
endmodule
